// file: shared/usc_pkg.sv
`default_nettype none
package usc_pkg;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_SBCR  = 32'h5000_1190;
  localparam logic [31:0] ADDR_SDMAM = 32'h5000_1194;
  localparam logic [31:0] ADDR_SFE   = 32'h5000_1198;
  localparam logic [31:0] ADDR_SRT   = 32'h5000_119C;
  localparam logic [31:0] ADDR_LINE  = 32'h5000_11B0;
  localparam logic [31:0] ADDR_FIFO  = 32'h5000_11B4;
  localparam logic [31:0] ADDR_MODEM = 32'h5000_11B8;
  localparam logic [31:0] ADDR_STAT  = 32'h5000_11BC;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LINE_BREAK_BIT = 6;
  localparam int MODEM_LOOP_BIT = 4;
  localparam int MODEM_IR_BIT   = 6;
  localparam int FIFO_EN_BIT    = 0;
  localparam int FIFO_DMA_BIT   = 3;
  localparam int FIFO_TXT_LSB   = 4;
  localparam int FIFO_TRIG_LSB  = 6;
  localparam int STAT_RXHIT    = 0;
  localparam int STAT_RXREQ    = 1;
  localparam int STAT_TXREQ    = 2;
  localparam int STAT_SOUT     = 3;

  // ---------------------------------------------------------------
  // reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] REG8_RST  = 8'h00;
  localparam logic [1:0] FIELD_RST = 2'h0;
  localparam logic [1:0] TRIG_ONE  = 2'h0;
  localparam logic [1:0] TRIG_HLFA = 2'h1;
  localparam logic [1:0] TRIG_HLFB = 2'h2;
  localparam logic [1:0] TRIG_TWOL = 2'h3;
  localparam int TRIG_GAP = 2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ        = 40_000_000;
  localparam int IR_PULSE_PERIOD_NS = 1000;
  localparam int IR_PULSE_CYCLES    =
    (IR_PULSE_PERIOD_NS * (CLK_FREQ_HZ / 1_000_000)) / 1000;
endpackage
`default_nettype wire

// file: shared/usc_field_if.sv
`timescale 1ns/1ps
`default_nettype none
interface usc_field_if #(parameter int W = 1);
  logic         wrShadow;
  logic         wrPrimary;
  logic [W-1:0] dShadow;
  logic [W-1:0] dPrimary;
  logic [W-1:0] q;
  modport ctrl (output wrShadow, wrPrimary, dShadow, dPrimary, input q);
  modport fld  (input wrShadow, wrPrimary, dShadow, dPrimary, output q);
endinterface
`default_nettype wire

// file: rtl/usc_field_reg.sv
`timescale 1ns/1ps
`default_nettype none
module usc_field_reg
  import usc_pkg::*;
#(
  parameter int         W   = 1,
  parameter logic [1:0] RST = FIELD_RST
) (
  input wire logic clk,
  input wire logic srst,
  usc_field_if.fld fb
);
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // ---------------------------------------------------------------
  // one state, two write locations
  // ---------------------------------------------------------------
  always_comb begin
    q_next = q_reg;
    if (fb.wrShadow) begin
      q_next = fb.dShadow;
    end else if (fb.wrPrimary) begin
      q_next = fb.dPrimary;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q_reg <= RST[W-1:0];
    end else begin
      q_reg <= q_next;
    end
  end

  assign fb.q = q_reg;
endmodule // usc_field_reg
`default_nettype wire

// file: rtl/usc_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
module usc_pulse_gen #(
  parameter int PERIOD = 40
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic run,
  output var  logic pulse_n
);
  localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [CW-1:0] TOP = CW'(PERIOD - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          pulse_reg;
  logic          pulse_next;

  // ---------------------------------------------------------------
  // one low cycle every PERIOD cycles while running
  // ---------------------------------------------------------------
  always_comb begin
    cnt_next   = TOP;
    pulse_next = 1'b1;
    if (run) begin
      cnt_next   = (cnt_reg == '0) ? TOP : cnt_reg - 1'b1;
      pulse_next = (cnt_reg != '0);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg   <= TOP;
      pulse_reg <= 1'b1;
    end else begin
      cnt_reg   <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulse_n = pulse_reg;
endmodule // usc_pulse_gen
`default_nettype wire

// file: rtl/usc_shadow_ctrl.sv
// Behaviour
// - the shadow break bit and the line control break bit are one state.
// - break with loopback off drives the serial output low until cleared.
// - break in infrared mode with loopback off pulses the active-low infrared output.
// - in loopback the break goes to the own receiver, not the line.
// - the shadow dma mode bit aliases the fifo control dma mode bit.
// - the shadow fifo enable aliases the fifo control enable bit.
// - fifo enable going 1 to 0 resets both fifo controllers.
// - the shadow receive trigger aliases the fifo control trigger field.
// - trigger 00 one char, 01 and 10 half full, 11 two less than full.
// - in dma mode 1 the receive request asserts at the trigger level.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module usc_shadow_ctrl
  import usc_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int LVL_W      = $clog2(FIFO_DEPTH + 1)
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [31:0]      avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output var  logic [31:0]      avs_readdata,
  output var  logic             avs_waitrequest,
  input  wire logic             txSerial,
  input  wire logic             irTxData_n,
  input  wire logic [LVL_W-1:0] rxLevel,
  input  wire logic [LVL_W-1:0] txLevel,
  output var  logic             serialOut,
  output var  logic             irOut_n,
  output var  logic             loopRx,
  output var  logic             fifoEnable,
  output var  logic             txFifoReset,
  output var  logic             rxFifoReset,
  output var  logic             rxThresholdHit,
  output var  logic             dmaMode,
  output var  logic             dmaTxReq_n,
  output var  logic             dmaRxReq_n
);
  localparam logic [LVL_W-1:0] LVL_ONE  = LVL_W'(1);
  localparam logic [LVL_W-1:0] LVL_HALF = LVL_W'(FIFO_DEPTH / 2);
  localparam logic [LVL_W-1:0] LVL_TWOL = LVL_W'(FIFO_DEPTH - TRIG_GAP);
  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(FIFO_DEPTH);

  // ---------------------------------------------------------------
  // avalon slave, one wait cycle per access
  // ---------------------------------------------------------------
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic [31:0] rdMux;
  logic        reqOn;
  logic        wrTake;

  assign reqOn           = avs_read | avs_write;
  assign avs_waitrequest = reqOn & ~ack_reg;
  assign wrTake          = avs_write & ack_reg & avs_byteenable[0];

  // ---------------------------------------------------------------
  // aliased fields
  // ---------------------------------------------------------------
  usc_field_if #(.W(1)) brkIf ();
  usc_field_if #(.W(1)) dmaIf ();
  usc_field_if #(.W(1)) fenIf ();
  usc_field_if #(.W(2)) trgIf ();

  assign brkIf.wrShadow  = wrTake && (avs_address == ADDR_SBCR);
  assign brkIf.wrPrimary = wrTake && (avs_address == ADDR_LINE);
  assign brkIf.dShadow   = avs_writedata[0];
  assign brkIf.dPrimary  = avs_writedata[LINE_BREAK_BIT];
  assign dmaIf.wrShadow  = wrTake && (avs_address == ADDR_SDMAM);
  assign dmaIf.wrPrimary = wrTake && (avs_address == ADDR_FIFO);
  assign dmaIf.dShadow   = avs_writedata[0];
  assign dmaIf.dPrimary  = avs_writedata[FIFO_DMA_BIT];
  assign fenIf.wrShadow  = wrTake && (avs_address == ADDR_SFE);
  assign fenIf.wrPrimary = wrTake && (avs_address == ADDR_FIFO);
  assign fenIf.dShadow   = avs_writedata[0];
  assign fenIf.dPrimary  = avs_writedata[FIFO_EN_BIT];
  assign trgIf.wrShadow  = wrTake && (avs_address == ADDR_SRT);
  assign trgIf.wrPrimary = wrTake && (avs_address == ADDR_FIFO);
  assign trgIf.dShadow   = avs_writedata[1:0];
  assign trgIf.dPrimary  = avs_writedata[FIFO_TRIG_LSB +: 2];

  usc_field_reg #(.W(1)) uBrk (.clk(clk), .srst(srst), .fb(brkIf));
  usc_field_reg #(.W(1)) uDma (.clk(clk), .srst(srst), .fb(dmaIf));
  usc_field_reg #(.W(1)) uFen (.clk(clk), .srst(srst), .fb(fenIf));
  usc_field_reg #(.W(2)) uTrg (.clk(clk), .srst(srst), .fb(trgIf));

  logic       brk;
  logic       fen;
  logic [1:0] trig;
  assign brk  = brkIf.q;
  assign fen  = fenIf.q;
  assign trig = trgIf.q;

  // ---------------------------------------------------------------
  // remaining control bits
  // ---------------------------------------------------------------
  logic [7:0] line_reg;
  logic [7:0] line_next;
  logic [7:0] modem_reg;
  logic [7:0] modem_next;
  logic [1:0] txt_reg;
  logic [1:0] txt_next;
  logic       loop;
  logic       irMode;

  assign loop   = modem_reg[MODEM_LOOP_BIT];
  assign irMode = modem_reg[MODEM_IR_BIT];

  always_comb begin
    line_next  = line_reg;
    modem_next = modem_reg;
    txt_next   = txt_reg;
    if (wrTake && (avs_address == ADDR_LINE)) begin
      line_next = avs_writedata[7:0];
      line_next[LINE_BREAK_BIT] = 1'b0;
    end
    if (wrTake && (avs_address == ADDR_MODEM)) begin
      modem_next = avs_writedata[7:0];
    end
    if (wrTake && (avs_address == ADDR_FIFO)) begin
      txt_next = avs_writedata[FIFO_TXT_LSB +: 2];
    end
  end

  // ---------------------------------------------------------------
  // read mux and bus handshake
  // ---------------------------------------------------------------
  always_comb begin
    rdMux = '0;
    unique case (avs_address)
      ADDR_SBCR:  rdMux[0]   = brk;
      ADDR_SDMAM: rdMux[0]   = dmaMode;
      ADDR_SFE:   rdMux[0]   = fen;
      ADDR_SRT:   rdMux[1:0] = trig;
      ADDR_LINE: begin
        rdMux[7:0] = line_reg;
        rdMux[LINE_BREAK_BIT] = brk;
      end
      ADDR_FIFO: begin
        rdMux[FIFO_EN_BIT]         = fen;
        rdMux[FIFO_DMA_BIT]        = dmaMode;
        rdMux[FIFO_TXT_LSB +: 2]   = txt_reg;
        rdMux[FIFO_TRIG_LSB +: 2]  = trig;
      end
      ADDR_MODEM: rdMux[7:0] = modem_reg;
      ADDR_STAT: begin
        rdMux[STAT_RXHIT] = rxThresholdHit;
        rdMux[STAT_RXREQ] = ~dmaRxReq_n;
        rdMux[STAT_TXREQ] = ~dmaTxReq_n;
        rdMux[STAT_SOUT]  = serialOut;
      end
      default:    rdMux = '0;
    endcase
  end

  always_comb begin
    ack_next = reqOn & ~ack_reg;
    rd_next  = rd_reg;
    if (avs_read && !ack_reg) begin
      rd_next = rdMux;
    end
  end

  // ---------------------------------------------------------------
  // line, infrared and loopback paths
  // ---------------------------------------------------------------
  logic irPulse_n;
  logic irBrk;
  logic sout_reg;
  logic sout_next;
  logic ir_reg;
  logic ir_next;
  logic lrx_reg;
  logic lrx_next;

  assign irBrk = irMode & brk & ~loop;

  usc_pulse_gen #(.PERIOD(IR_PULSE_CYCLES)) uIrp (
    .clk     (clk),
    .srst    (srst),
    .run     (irBrk),
    .pulse_n (irPulse_n)
  );

  always_comb begin
    sout_next = loop ? 1'b1 : (brk ? 1'b0 : txSerial);
    lrx_next  = loop ? (brk ? 1'b0 : txSerial) : 1'b1;
    ir_next   = 1'b1;
    if (irMode && !loop) begin
      ir_next = brk ? irPulse_n : irTxData_n;
    end
  end

  // ---------------------------------------------------------------
  // fifo enable, trigger and dma requests
  // ---------------------------------------------------------------
  logic fenQ_reg;
  logic frst_reg;
  logic frst_next;
  logic hit;
  logic hit_reg;
  logic rxHold_reg;
  logic rxHold_next;
  logic txHold_reg;
  logic txHold_next;

  assign frst_next = fenQ_reg & ~fen;

  always_comb begin
    hit = (rxLevel >= LVL_ONE);
    if (fen) begin
      unique case (trig)
        TRIG_ONE:             hit = (rxLevel >= LVL_ONE);
        TRIG_HLFA, TRIG_HLFB: hit = (rxLevel >= LVL_HALF);
        TRIG_TWOL:            hit = (rxLevel >= LVL_TWOL);
      endcase
    end
  end

  always_comb begin
    rxHold_next = rxHold_reg;
    txHold_next = txHold_reg;
    if (!dmaMode) begin
      rxHold_next = (rxLevel != '0);
      txHold_next = (txLevel == '0);
    end else begin
      if (hit) begin
        rxHold_next = 1'b1;
      end else if (rxLevel == '0) begin
        rxHold_next = 1'b0;
      end
      if (txLevel == '0) begin
        txHold_next = 1'b1;
      end else if (txLevel == LVL_FULL) begin
        txHold_next = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_reg    <= 1'b0;
      rd_reg     <= '0;
      line_reg   <= REG8_RST;
      modem_reg  <= REG8_RST;
      txt_reg    <= FIELD_RST;
      sout_reg   <= 1'b1;
      ir_reg     <= 1'b1;
      lrx_reg    <= 1'b1;
      fenQ_reg   <= 1'b0;
      frst_reg   <= 1'b0;
      hit_reg    <= 1'b0;
      rxHold_reg <= 1'b0;
      txHold_reg <= 1'b0;
    end else begin
      ack_reg    <= ack_next;
      rd_reg     <= rd_next;
      line_reg   <= line_next;
      modem_reg  <= modem_next;
      txt_reg    <= txt_next;
      sout_reg   <= sout_next;
      ir_reg     <= ir_next;
      lrx_reg    <= lrx_next;
      fenQ_reg   <= fen;
      frst_reg   <= frst_next;
      hit_reg    <= hit;
      rxHold_reg <= rxHold_next;
      txHold_reg <= txHold_next;
    end
  end

  assign avs_readdata   = rd_reg;
  assign serialOut      = sout_reg;
  assign irOut_n        = ir_reg;
  assign loopRx         = lrx_reg;
  assign fifoEnable     = fenQ_reg;
  assign txFifoReset    = frst_reg;
  assign rxFifoReset    = frst_reg;
  assign rxThresholdHit = hit_reg;
  assign dmaMode        = dmaIf.q;
  assign dmaTxReq_n     = ~txHold_reg;
  assign dmaRxReq_n     = ~rxHold_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  localparam int IR_BOUND = IR_PULSE_CYCLES + 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_sbcrWrite;
    wrTake && avs_address == ADDR_SBCR;
  endsequence
  sequence s_lineRead;
    avs_read && !avs_waitrequest && avs_address == ADDR_LINE;
  endsequence

  property p_brkAlias;
    s_sbcrWrite |=> brk == $past(avs_writedata[0]);
  endproperty
  a_brkAlias: assert property (p_brkAlias)
    else $error("break alias write wrong");

  property p_brkRead;
    s_lineRead |-> avs_readdata[LINE_BREAK_BIT] == brk;
  endproperty
  a_brkRead: assert property (p_brkRead)
    else $error("break alias readback wrong");

  property p_brkLow;
    (brk && !loop) |=> !serialOut;
  endproperty
  a_brkLow: assert property (p_brkLow)
    else $error("serial output not low in break");

  property p_irPulse;
    irBrk |-> ##[1:IR_BOUND] (!irOut_n || !irBrk);
  endproperty
  a_irPulse: assert property (p_irPulse)
    else $error("infrared output not pulsing in break");

  property p_loopBrk;
    (loop && brk) |=> serialOut && !loopRx;
  endproperty
  a_loopBrk: assert property (p_loopBrk)
    else $error("loopback break leaked to line");

  property p_dmaAlias;
    (wrTake && avs_address == ADDR_FIFO) |=>
      dmaMode == $past(avs_writedata[FIFO_DMA_BIT]);
  endproperty
  a_dmaAlias: assert property (p_dmaAlias)
    else $error("dma mode alias wrong");

  property p_fenAlias;
    (wrTake && avs_address == ADDR_SFE) |=> ##1
      fifoEnable == $past(avs_writedata[0], 2);
  endproperty
  a_fenAlias: assert property (p_fenAlias)
    else $error("fifo enable alias wrong");

  property p_fifoReset;
    $fell(fen) |=> txFifoReset && rxFifoReset ##1 !txFifoReset;
  endproperty
  a_fifoReset: assert property (p_fifoReset)
    else $error("fifo reset pulse missing");

  property p_trigAlias;
    (wrTake && avs_address == ADDR_SRT) |=> trig == $past(avs_writedata[1:0]);
  endproperty
  a_trigAlias: assert property (p_trigAlias)
    else $error("receive trigger alias wrong");

  property p_trigTwoLess;
    (fen && trig == TRIG_TWOL) |=>
      rxThresholdHit == ($past(rxLevel) >= LVL_TWOL);
  endproperty
  a_trigTwoLess: assert property (p_trigTwoLess)
    else $error("two-less trigger level wrong");

  property p_rxReq;
    (dmaMode && hit) |=> !dmaRxReq_n;
  endproperty
  a_rxReq: assert property (p_rxReq)
    else $error("receive dma request not asserted");

  property p_upperZero;
    (avs_read && !avs_waitrequest && avs_address == ADDR_SRT)
      |-> avs_readdata[31:2] == '0;
  endproperty
  a_upperZero: assert property (p_upperZero)
    else $error("reserved bits not zero");
endmodule // usc_shadow_ctrl
`default_nettype wire

// file: dv/usc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// fifo levels and transmitter line seen by the shadow block
// ---------------------------------------------------------------
module usc_far_model #(
  parameter int LVL_W = 5
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             loadRx,
  input  wire logic [LVL_W-1:0] newRx,
  input  wire logic             rxFifoReset,
  input  wire logic             txFifoReset,
  output var  logic [LVL_W-1:0] rxLevel,
  output var  logic [LVL_W-1:0] txLevel,
  output var  logic             txSerial,
  output var  logic             irTxData_n
);
  always_ff @(posedge clk) begin
    if (srst) begin
      rxLevel    <= '0;
      txLevel    <= LVL_W'(4);
      txSerial   <= 1'b1;
      irTxData_n <= 1'b1;
    end else begin
      // line toggles so a forced level shows
      txSerial   <= ~txSerial;
      irTxData_n <= 1'b1;
      if (rxFifoReset) begin
        rxLevel <= '0;
      end else if (loadRx) begin
        rxLevel <= newRx;
      end
      if (txFifoReset) begin
        txLevel <= '0;
      end
    end
  end
endmodule // usc_far_model
`default_nettype wire

// file: dv/uart_shadow_control_bits_test.sv
`timescale 1ns/1ps
`default_nettype none
module uart_shadow_control_bits_test
  import usc_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int          DEPTH  = 16;
  localparam logic [31:0] LINE_A = ADDR_SBCR + 32'h0000_0020;
  localparam logic [31:0] FIFO_A = ADDR_SBCR + 32'h0000_0024;
  localparam logic [31:0] MODE_A = ADDR_SBCR + 32'h0000_0028;
  localparam logic [31:0] NONE_A = 32'h5000_1200;
  typedef struct packed {
    logic [31:0] wa;
    logic [31:0] wd;
    logic [31:0] ra;
    logic [31:0] ex;
  } usc_row_s;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [31:0] avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        txSerial, irTxData_n, loadRx = 1'b0;
  logic [4:0]  rxLevel, txLevel, newRx = '0;
  logic        serialOut, irOut_n, loopRx, fifoEnable, rxThresholdHit;
  logic        txFifoReset, rxFifoReset, dmaMode, dmaTxReq_n, dmaRxReq_n;
  int          errors = 0;
  int          total_checks = 0;
  int          rstPulses = 0;
  logic [31:0] q;
  usc_row_s    rows [13];
  int          thr [4];
  int          n;
  logic        prev;

  always #12.5 clk = ~clk;

  usc_shadow_ctrl usc_shadow_ctrl_inst (
    .clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .txSerial(txSerial), .irTxData_n(irTxData_n), .rxLevel(rxLevel),
    .txLevel(txLevel), .serialOut(serialOut), .irOut_n(irOut_n),
    .loopRx(loopRx), .fifoEnable(fifoEnable), .txFifoReset(txFifoReset),
    .rxFifoReset(rxFifoReset), .rxThresholdHit(rxThresholdHit),
    .dmaMode(dmaMode), .dmaTxReq_n(dmaTxReq_n), .dmaRxReq_n(dmaRxReq_n)
  );

  usc_far_model #(.LVL_W(5)) usc_far_model_inst (
    .clk(clk), .srst(srst), .loadRx(loadRx), .newRx(newRx),
    .rxFifoReset(rxFifoReset), .txFifoReset(txFifoReset),
    .rxLevel(rxLevel), .txLevel(txLevel), .txSerial(txSerial),
    .irTxData_n(irTxData_n)
  );

  always @(posedge clk) begin
    if (rxFifoReset === 1'b1 && txFifoReset === 1'b1) begin
      rstPulses++;
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic bus(input logic [31:0] a, input logic wr,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      errors++;
      $display("Error waitrequest expected 0 seen %b", avs_waitrequest);
    end
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(a, 1'b1, d, t);
    repeat (3) @(negedge clk);
  endtask

  task automatic set_rx(input logic [4:0] v);
    @(posedge clk);
    loadRx <= 1'b1;
    newRx  <= v;
    @(posedge clk);
    loadRx <= 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rows = '{
      '{ADDR_SBCR, 32'h0000_FFFF, ADDR_SBCR, 32'h0000_0001},
      '{ADDR_SBCR, 32'h0000_0001, LINE_A,    32'h0000_0040},
      '{LINE_A,    32'h0000_0000, ADDR_SBCR, 32'h0000_0000},
      '{LINE_A,    32'h0000_0040, ADDR_SBCR, 32'h0000_0001},
      '{ADDR_SBCR, 32'h0000_0000, LINE_A,    32'h0000_0000},
      '{ADDR_SDMAM, 32'h0000_FFFF, ADDR_SDMAM, 32'h0000_0001},
      '{ADDR_SDMAM, 32'h0000_0001, FIFO_A,   32'h0000_0008},
      '{FIFO_A,    32'h0000_0001, ADDR_SDMAM, 32'h0000_0000},
      '{ADDR_SFE,  32'h0000_0000, FIFO_A,    32'h0000_0000},
      '{ADDR_SRT,  32'h0000_FFFF, FIFO_A,    32'h0000_00C0},
      '{FIFO_A,    32'h0000_0040, ADDR_SRT,  32'h0000_0001},
      '{ADDR_SRT,  32'h0000_0000, ADDR_SFE,  32'h0000_0000},
      '{NONE_A,    32'h0000_00FF, NONE_A,    32'h0000_0000}
    };
    thr = '{1, DEPTH / 2, DEPTH / 2, DEPTH - TRIG_GAP};
    fork
      begin
        #750000;
        errors++;
        $display("Error watchdog expected done seen hang");
        tally_and_finish();
      end
    join_none
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(negedge clk);
    check("serialOut", 1, serialOut);
    check("dmaMode", 0, dmaMode);
    check("dmaTxReq_n", 1, dmaTxReq_n);
    for (int i = 0; i < 4; i++) begin
      bus(ADDR_SBCR + 32'(4 * i), 1'b0, 32'h0, q);
      check("shadow reset", 32'h0, q);
    end
    $display("reset test done");

    for (int i = 0; i < 13; i++) begin
      wr(rows[i].wa, rows[i].wd);
      bus(rows[i].ra, 1'b0, 32'h0, q);
      check("row readback", rows[i].ex, q);
    end
    avs_byteenable <= 4'h0;
    wr(ADDR_SBCR, 32'h0000_0001);
    @(posedge clk);
    avs_byteenable <= 4'hF;
    bus(ADDR_SBCR, 1'b0, 32'h0, q);
    check("lane off", 32'h0, q);
    $display("table test done");

    wr(ADDR_SBCR, 32'h0000_0001);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      check("serialOut break", 0, serialOut);
    end
    wr(ADDR_SBCR, 32'h0000_0000);
    prev = serialOut;
    @(negedge clk);
    check("serialOut free", {31'h0, ~prev}, serialOut);
    $display("break test done");

    wr(MODE_A, 32'h0000_0040);
    check("irOut_n idle", 1, irOut_n);
    wr(ADDR_SBCR, 32'h0000_0001);
    n = 0;
    for (int i = 0; i < 3 * IR_PULSE_CYCLES; i++) begin
      @(negedge clk);
      if (irOut_n === 1'b0) begin
        n++;
      end
    end
    check("ir pulses", 3, n);
    wr(MODE_A, 32'h0000_0010);
    check("serialOut loop", 1, serialOut);
    check("loopRx", 0, loopRx);
    check("irOut_n loop", 1, irOut_n);
    wr(ADDR_SBCR, 32'h0000_0000);
    prev = loopRx;
    @(negedge clk);
    check("loopRx free", {31'h0, ~prev}, loopRx);
    wr(MODE_A, 32'h0000_0000);
    $display("infrared and loopback test done");

    wr(ADDR_SFE, 32'h0000_0001);
    check("fifoEnable", 1, fifoEnable);
    set_rx(5'h09);
    check("rx req mode 0", 0, dmaRxReq_n);
    n = rstPulses;
    wr(ADDR_SFE, 32'h0000_0000);
    check("fifo reset pulses", n + 1, rstPulses);
    check("rxLevel", 0, rxLevel);
    check("txLevel", 0, txLevel);
    check("fifoEnable off", 0, fifoEnable);
    wr(ADDR_SFE, 32'h0000_0000);
    check("no second pulse", n + 1, rstPulses);
    $display("fifo reset test done");

    for (int t = 0; t < 4; t++) begin
      wr(FIFO_A, 32'(t * 64 + 9));
      check("dmaMode set", 1, dmaMode);
      check("tx req empty", 0, dmaTxReq_n);
      set_rx(5'(thr[t] - 1));
      check("hit below", 0, rxThresholdHit);
      check("rx req below", 1, dmaRxReq_n);
      set_rx(5'(thr[t]));
      check("hit at level", 1, rxThresholdHit);
      check("rx req at level", 0, dmaRxReq_n);
      set_rx(5'h00);
      check("rx req empty", 1, dmaRxReq_n);
    end
    $display("trigger test done");
    tally_and_finish();
  end
endmodule // uart_shadow_control_bits_test
`default_nettype wire
